// *** pfl_regs.vh ***
/*
 Register map, field positions, reset values and timing constants of the
 fan loop setup block. Included by the design file; definitions only.
*/
`ifndef PFL_REGS_VH
`define PFL_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PFL_ADDR_FILTER     8'h32
`define PFL_ADDR_SHUT1      8'h33
`define PFL_ADDR_SHUT2      8'h34
`define PFL_ADDR_BIND       8'h35
`define PFL_ADDR_FLOOR_HYST 8'h36
`define PFL_ADDR_TGT1       8'h37
`define PFL_ADDR_TGT2       8'h38
`define PFL_ADDR_OFF1       8'h39
`define PFL_ADDR_OFF2       8'h3a
`define PFL_ADDR_PGAIN      8'h3b
`define PFL_ADDR_IGAIN      8'h3c
`define PFL_ADDR_EXP        8'h3d

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define PFL_RST_ZERO        8'h00
`define PFL_RST_BIND        8'h30
`define PFL_RST_OFF         8'h80
`define PFL_MASK_FILTER     8'h77
`define PFL_MASK_SHUT       8'hf8
`define PFL_MASK_EXP        8'h0f
`define PFL_OFF_DISABLED    8'h80

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PFL_FC1_RANGE       2:0
`define PFL_FC2_RANGE       6:4
`define PFL_SHUT_RANGE      7:3
`define PFL_HYST_RANGE      3:0
`define PFL_FLOOR_RANGE     7:4
`define PFL_ICE_RANGE       1:0
`define PFL_PCE_RANGE       3:2
`define PFL_B_LOOP_USES_ZONE1         0
`define PFL_B_LOOP_USES_ZONE2         1
`define PFL_B_OUT1_PI       2
`define PFL_B_OUT2_PI       3
`define PFL_B_T1_Z1         4
`define PFL_B_T2_Z2         5
`define PFL_B_T3_Z1         6
`define PFL_B_T4_Z2         7

// ----------------------------------------------------------------
// Duty scaling and timing
// ----------------------------------------------------------------
`define PFL_DUTY_FULL       9'h100
`define PFL_FILT_FRAC       7
`define PFL_PI_FRAC         4
`define PFL_CLK_PERIOD_NS   5
`define PFL_FILT_TICK_US    16333
`define PFL_PI_TICK_US      250000

`endif

// *** pfl_fan_loop.v ***
/*
 PI fan loop setup block: configuration registers, per-output IIR smoothing
 of low-resolution duty sources with shutoff threshold, PI controller bound
 to zones 1/2, lookup-table zone routing and two PWM fan outputs.
 Assumes a byte register port in the core_clk domain and temperature and
 table duty inputs already synchronous to core_clk.
*/
`default_nettype none
`include "pfl_regs.vh"

// Function
// - Each output has a 3-bit smoothing code; zero bypasses its low-resolution filter.
// - Codes 001..111 give settling from about 0.098 s to 6.272 s, doubling.
// - Cutoff field bits 7:3 times eight is the 9-bit duty threshold.
// - Filtered duty below threshold zeroes that output's filtered duty; routed loop duty still applies.
// - When the filter is bypassed, the cutoff threshold is ignored too.
// - Bindings bits 0 and 1 attach the loop to zone 1 and zone 2.
// - Bindings bits 2 and 3 route loop duty to fan outputs 1 and 2.
// - Bits 7:4 pick zone 1/2 over zone 3/4 for tables; reset 30h.
// - Hysteresis field bits 3:0 gives a band in 0.5 degree steps.
// - Floor field bits 7:4 sets minimum loop duty in 6.25% steps.
// - Loop holds hotter bound zone between its target and target minus hysteresis.
// - At or below the hotter bound zone's off temperature loop duty is zero; 80h disables.
// - Integral gain is scaled by signed exponent in bits 1:0, -2..+1.
// - Proportional gain is scaled by signed exponent in bits 3:2, -2..+1.
// - Reported duty is upper eight bits of the max of bound sources.
module pfl_fan_loop #(
  parameter integer FILT_TICK_CYC = (`PFL_FILT_TICK_US * 1000) / `PFL_CLK_PERIOD_NS,
  parameter integer PI_TICK_CYC   = (`PFL_PI_TICK_US * 1000) / `PFL_CLK_PERIOD_NS,
  parameter integer PWM_DIV       = 8
) (
  input  wire       core_clk,
  input  wire       rst,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire [7:0] zone1_temp,
  input  wire [7:0] zone2_temp,
  input  wire [7:0] zone3_temp,
  input  wire [7:0] zone4_temp,
  input  wire [8:0] out1_lowres_duty,
  input  wire [8:0] out2_lowres_duty,
  output reg  [7:0] table1_temp,
  output reg  [7:0] table2_temp,
  output reg  [7:0] table3_temp,
  output reg  [7:0] table4_temp,
  output reg  [7:0] out1_duty_report,
  output reg  [7:0] out2_duty_report,
  output reg  [8:0] loop_duty,
  output reg        fan_output_1,
  output reg        fan_output_2
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  reg [7:0] duty_filter_coefficients;
  reg [7:0] output1_shutoff_threshold;
  reg [7:0] output2_shutoff_threshold;
  reg [7:0] controller_source_bindings;
  reg [7:0] loop_floor_and_hysteresis;
  reg [7:0] zone1_target_temp;
  reg [7:0] zone2_target_temp;
  reg [7:0] zone1_off_temp;
  reg [7:0] zone2_off_temp;
  reg [7:0] proportional_gain;
  reg [7:0] integral_gain;
  reg [7:0] gain_exponents;

  always @(posedge core_clk) begin
    if (rst) begin
      duty_filter_coefficients   <= `PFL_RST_ZERO;
      output1_shutoff_threshold  <= `PFL_RST_ZERO;
      output2_shutoff_threshold  <= `PFL_RST_ZERO;
      controller_source_bindings <= `PFL_RST_BIND;
      loop_floor_and_hysteresis  <= `PFL_RST_ZERO;
      zone1_target_temp          <= `PFL_RST_ZERO;
      zone2_target_temp          <= `PFL_RST_ZERO;
      zone1_off_temp             <= `PFL_RST_OFF;
      zone2_off_temp             <= `PFL_RST_OFF;
      proportional_gain          <= `PFL_RST_ZERO;
      integral_gain              <= `PFL_RST_ZERO;
      gain_exponents             <= `PFL_RST_ZERO;
    end else if (reg_wr) begin
      case (reg_addr)
        `PFL_ADDR_FILTER:     duty_filter_coefficients <= reg_wdata & `PFL_MASK_FILTER;
        `PFL_ADDR_SHUT1:      output1_shutoff_threshold <= reg_wdata & `PFL_MASK_SHUT;
        `PFL_ADDR_SHUT2:      output2_shutoff_threshold <= reg_wdata & `PFL_MASK_SHUT;
        `PFL_ADDR_BIND:       controller_source_bindings <= reg_wdata;
        `PFL_ADDR_FLOOR_HYST: loop_floor_and_hysteresis <= reg_wdata;
        `PFL_ADDR_TGT1:       zone1_target_temp <= reg_wdata;
        `PFL_ADDR_TGT2:       zone2_target_temp <= reg_wdata;
        `PFL_ADDR_OFF1:       zone1_off_temp <= reg_wdata;
        `PFL_ADDR_OFF2:       zone2_off_temp <= reg_wdata;
        `PFL_ADDR_PGAIN:      proportional_gain <= reg_wdata;
        `PFL_ADDR_IGAIN:      integral_gain <= reg_wdata;
        `PFL_ADDR_EXP:        gain_exponents <= reg_wdata & `PFL_MASK_EXP;
        default:              ;
      endcase
    end
  end

  // Read data is combinational so a read sees the value in the same cycle
  always @* begin
    case (reg_addr)
      `PFL_ADDR_FILTER:     reg_rdata = duty_filter_coefficients;
      `PFL_ADDR_SHUT1:      reg_rdata = output1_shutoff_threshold;
      `PFL_ADDR_SHUT2:      reg_rdata = output2_shutoff_threshold;
      `PFL_ADDR_BIND:       reg_rdata = controller_source_bindings;
      `PFL_ADDR_FLOOR_HYST: reg_rdata = loop_floor_and_hysteresis;
      `PFL_ADDR_TGT1:       reg_rdata = zone1_target_temp;
      `PFL_ADDR_TGT2:       reg_rdata = zone2_target_temp;
      `PFL_ADDR_OFF1:       reg_rdata = zone1_off_temp;
      `PFL_ADDR_OFF2:       reg_rdata = zone2_off_temp;
      `PFL_ADDR_PGAIN:      reg_rdata = proportional_gain;
      `PFL_ADDR_IGAIN:      reg_rdata = integral_gain;
      `PFL_ADDR_EXP:        reg_rdata = gain_exponents;
      default:              reg_rdata = `PFL_RST_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [8:0] max9;
    input [8:0] a;
    input [8:0] b;
    begin
      max9 = (a > b) ? a : b;
    end
  endfunction

  // Signed exponent: 10b=-2, 11b=-1, 00b=0, 01b=+1
  function signed [23:0] exp_scale;
    input signed [23:0] v;
    input        [1:0]  e;
    begin
      case (e)
        2'b01:   exp_scale = v <<< 1;
        2'b11:   exp_scale = v >>> 1;
        2'b10:   exp_scale = v >>> 2;
        default: exp_scale = v;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Lookup-table zone routing
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      table1_temp <= `PFL_RST_ZERO;
      table2_temp <= `PFL_RST_ZERO;
      table3_temp <= `PFL_RST_ZERO;
      table4_temp <= `PFL_RST_ZERO;
    end else begin
      table1_temp <= controller_source_bindings[`PFL_B_T1_Z1] ? zone1_temp : zone3_temp;
      table2_temp <= controller_source_bindings[`PFL_B_T2_Z2] ? zone2_temp : zone4_temp;
      table3_temp <= controller_source_bindings[`PFL_B_T3_Z1] ? zone1_temp : zone3_temp;
      table4_temp <= controller_source_bindings[`PFL_B_T4_Z2] ? zone2_temp : zone4_temp;
    end
  end

  // ----------------------------------------------------------------
  // Low-resolution smoothing and shutoff
  // ----------------------------------------------------------------
  // Update tick: settling takes about three time constants of 2^code ticks,
  // so each code step doubles the settling interval.
  reg [31:0] filt_cnt;
  wire       filt_tick = (filt_cnt == FILT_TICK_CYC - 1);

  always @(posedge core_clk) begin
    if (rst || filt_tick) begin
      filt_cnt <= 32'h0000_0000;
    end else begin
      filt_cnt <= filt_cnt + 32'h0000_0001;
    end
  end

  wire [2:0] out1_smoothing_code = duty_filter_coefficients[`PFL_FC1_RANGE];
  wire [2:0] out2_smoothing_code = duty_filter_coefficients[`PFL_FC2_RANGE];
  wire [4:0] out1_cutoff_level   = output1_shutoff_threshold[`PFL_SHUT_RANGE];
  wire [4:0] out2_cutoff_level   = output2_shutoff_threshold[`PFL_SHUT_RANGE];

  reg  [15:0] filt1_acc;
  reg  [15:0] filt2_acc;
  wire signed [16:0] diff1 = $signed({1'b0, out1_lowres_duty, 7'h00}) - $signed({1'b0, filt1_acc});
  wire signed [16:0] diff2 = $signed({1'b0, out2_lowres_duty, 7'h00}) - $signed({1'b0, filt2_acc});
  wire signed [16:0] step1 = diff1 >>> out1_smoothing_code;
  wire signed [16:0] step2 = diff2 >>> out2_smoothing_code;

  always @(posedge core_clk) begin
    if (rst) begin
      filt1_acc <= 16'h0000;
      filt2_acc <= 16'h0000;
    end else begin
      if (out1_smoothing_code == 3'h0) begin
        filt1_acc <= {out1_lowres_duty, 7'h00};
      end else if (filt_tick) begin
        filt1_acc <= filt1_acc + step1[15:0];
      end
      if (out2_smoothing_code == 3'h0) begin
        filt2_acc <= {out2_lowres_duty, 7'h00};
      end else if (filt_tick) begin
        filt2_acc <= filt2_acc + step2[15:0];
      end
    end
  end

  wire [8:0] filt1_duty = filt1_acc[15:`PFL_FILT_FRAC];
  wire [8:0] filt2_duty = filt2_acc[15:`PFL_FILT_FRAC];
  wire [8:0] thresh1    = {1'b0, out1_cutoff_level, 3'h0};
  wire [8:0] thresh2    = {1'b0, out2_cutoff_level, 3'h0};
  // A bypassed filter also disables its threshold
  wire cut1 = (out1_smoothing_code != 3'h0) && (filt1_duty < thresh1);
  wire cut2 = (out2_smoothing_code != 3'h0) && (filt2_duty < thresh2);
  wire [8:0] low1 = cut1 ? 9'h000 : filt1_duty;
  wire [8:0] low2 = cut2 ? 9'h000 : filt2_duty;

  // ----------------------------------------------------------------
  // PI controller
  // ----------------------------------------------------------------
  wire loop_uses_zone1   = controller_source_bindings[`PFL_B_LOOP_USES_ZONE1];
  wire loop_uses_zone2   = controller_source_bindings[`PFL_B_LOOP_USES_ZONE2];
  wire out1_follows_loop = controller_source_bindings[`PFL_B_OUT1_PI];
  wire out2_follows_loop = controller_source_bindings[`PFL_B_OUT2_PI];
  wire [3:0] loop_hysteresis   = loop_floor_and_hysteresis[`PFL_HYST_RANGE];
  wire [3:0] loop_duty_floor   = loop_floor_and_hysteresis[`PFL_FLOOR_RANGE];
  wire [1:0] integral_exponent     = gain_exponents[`PFL_ICE_RANGE];
  wire [1:0] proportional_exponent = gain_exponents[`PFL_PCE_RANGE];

  // Hotter bound zone and its own target and off temperature
  wire pick_z2 = loop_uses_zone2 &&
                 (!loop_uses_zone1 || ($signed(zone2_temp) > $signed(zone1_temp)));
  wire [7:0] hot_temp = pick_z2 ? zone2_temp : zone1_temp;
  wire [7:0] hot_tgt  = pick_z2 ? zone2_target_temp : zone1_target_temp;
  wire [7:0] hot_off  = pick_z2 ? zone2_off_temp : zone1_off_temp;
  wire loop_active    = loop_uses_zone1 || loop_uses_zone2;
  wire off_hit = (hot_off != `PFL_OFF_DISABLED) && ($signed(hot_temp) <= $signed(hot_off));

  // Error in half-degree units; zero inside the hysteresis band
  wire signed [10:0] t_half   = $signed({hot_temp[7], hot_temp, 2'b00}) >>> 1;
  wire signed [10:0] tgt_half = $signed({hot_tgt[7], hot_tgt, 2'b00}) >>> 1;
  wire signed [10:0] low_half = tgt_half - $signed({7'h00, loop_hysteresis});
  reg  signed [10:0] err;

  always @* begin
    if (t_half > tgt_half) begin
      err = t_half - tgt_half;
    end else if (t_half < low_half) begin
      err = t_half - low_half;
    end else begin
      err = 11'sh000;
    end
  end

  wire signed [19:0] p_raw = $signed({1'b0, proportional_gain}) * err;
  wire signed [19:0] i_raw = $signed({1'b0, integral_gain}) * err;
  wire signed [23:0] p_term = exp_scale({{4{p_raw[19]}}, p_raw}, proportional_exponent);
  wire signed [23:0] i_term = exp_scale({{4{i_raw[19]}}, i_raw}, integral_exponent);
  wire signed [23:0] int_max = $signed({11'h000, `PFL_DUTY_FULL, 4'h0});

  reg  signed [23:0] integ;
  wire signed [23:0] integ_sum = integ + i_term;
  wire signed [23:0] next_integ = (integ_sum < 24'sh00_0000) ? 24'sh00_0000 :
                                  (integ_sum > int_max) ? int_max : integ_sum;
  wire signed [23:0] pi_sum  = (p_term + next_integ) >>> `PFL_PI_FRAC;
  wire [8:0] floor_duty = {1'b0, loop_duty_floor, 4'h0};
  wire [8:0] raw_duty   = (pi_sum < 24'sh00_0000) ? 9'h000 :
                          (pi_sum > $signed({15'h0000, `PFL_DUTY_FULL})) ? `PFL_DUTY_FULL :
                          pi_sum[8:0];
  wire [8:0] next_loop_duty = max9(raw_duty, floor_duty);

  reg [31:0] pi_cnt;
  wire       pi_tick = (pi_cnt == PI_TICK_CYC - 1);

  always @(posedge core_clk) begin
    if (rst || pi_tick) begin
      pi_cnt <= 32'h0000_0000;
    end else begin
      pi_cnt <= pi_cnt + 32'h0000_0001;
    end
  end

  // Integral is cleared while idle or off so the loop restarts without windup
  always @(posedge core_clk) begin
    if (rst) begin
      integ     <= 24'sh00_0000;
      loop_duty <= 9'h000;
    end else if (!loop_active || off_hit) begin
      integ     <= 24'sh00_0000;
      loop_duty <= 9'h000;
    end else if (pi_tick) begin
      integ     <= next_integ;
      loop_duty <= next_loop_duty;
    end
  end

  // ----------------------------------------------------------------
  // Output combine and PWM
  // ----------------------------------------------------------------
  wire [8:0] duty1 = max9(low1, out1_follows_loop ? loop_duty : 9'h000);
  wire [8:0] duty2 = max9(low2, out2_follows_loop ? loop_duty : 9'h000);

  reg [15:0] pwm_div_cnt;
  reg [7:0]  pwm_phase;
  wire       pwm_step = (pwm_div_cnt == PWM_DIV - 1);

  always @(posedge core_clk) begin
    if (rst) begin
      pwm_div_cnt      <= 16'h0000;
      pwm_phase        <= 8'h00;
      out1_duty_report <= 8'h00;
      out2_duty_report <= 8'h00;
      fan_output_1     <= 1'b0;
      fan_output_2     <= 1'b0;
    end else begin
      pwm_div_cnt      <= pwm_step ? 16'h0000 : pwm_div_cnt + 16'h0001;
      pwm_phase        <= pwm_step ? pwm_phase + 8'h01 : pwm_phase;
      out1_duty_report <= duty1[8:1];
      out2_duty_report <= duty2[8:1];
      fan_output_1     <= ({1'b0, pwm_phase} < duty1);
      fan_output_2     <= ({1'b0, pwm_phase} < duty2);
    end
  end

endmodule // pfl_fan_loop
`default_nettype wire

// *** pfl_monitor.sv ***
/*
 Assertion checker for the fan loop setup block.
 Assumes it is bound to pfl_fan_loop and sees only that module's ports.
*/
`default_nettype none
module pfl_monitor (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] zone1_temp,
  input wire logic [7:0] zone2_temp,
  input wire logic [7:0] zone3_temp,
  input wire logic [7:0] zone4_temp,
  input wire logic [7:0] table1_temp,
  input wire logic [7:0] table2_temp,
  input wire logic [7:0] table3_temp,
  input wire logic [7:0] table4_temp,
  input wire logic [7:0] out1_duty_report,
  input wire logic [7:0] out2_duty_report,
  input wire logic [8:0] loop_duty,
  input wire logic       fan_output_1
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Shadow of the bindings register
  // ----------------------------------------------------------------
  // Outputs stay zero for one edge after reset, so relations wait two edges
  logic [7:0] bind_q;
  logic [1:0] since_rst;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bind_q    <= 8'h30;
      since_rst <= 2'd0;
    end else begin
      if (reg_wr && reg_addr == 8'h35) bind_q <= reg_wdata;
      if (since_rst != 2'd3) since_rst <= since_rst + 2'd1;
    end
  end
  a_table1_route: assert property (since_rst[1] |-> table1_temp ==
    ($past(bind_q[4]) ? $past(zone1_temp) : $past(zone3_temp))) else $error("table1 source wrong");
  a_table2_route: assert property (since_rst[1] |-> table2_temp ==
    ($past(bind_q[5]) ? $past(zone2_temp) : $past(zone4_temp))) else $error("table2 source wrong");
  a_table3_route: assert property (since_rst[1] |-> table3_temp ==
    ($past(bind_q[6]) ? $past(zone1_temp) : $past(zone3_temp))) else $error("table3 source wrong");
  a_table4_route: assert property (since_rst[1] |-> table4_temp ==
    ($past(bind_q[7]) ? $past(zone2_temp) : $past(zone4_temp))) else $error("table4 source wrong");
  a_bind_readback: assert property (reg_addr == 8'h35 |-> reg_rdata == bind_q)
    else $error("bindings readback wrong");
  a_reserved_read: assert property ((reg_addr == 8'h32 |-> reg_rdata[7] == 1'b0 &&
    reg_rdata[3] == 1'b0) and ((reg_addr == 8'h33 || reg_addr == 8'h34) |->
    reg_rdata[2:0] == 3'h0) and (reg_addr == 8'h3d |-> reg_rdata[7:4] == 4'h0))
    else $error("reserved bits not zero");
  a_unmapped_zero: assert property ((reg_addr < 8'h32 || reg_addr > 8'h3d) |->
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_loop_unbound: assert property (since_rst[1] && $past(bind_q[1:0]) == 2'b00 |->
    loop_duty == 9'h000) else $error("loop duty without zone");
  a_out1_loop: assert property (since_rst[1] && $past(bind_q[2]) |->
    out1_duty_report >= $past(loop_duty[8:1])) else $error("out1 below loop duty");
  a_out2_loop: assert property (since_rst[1] && $past(bind_q[3]) |->
    out2_duty_report >= $past(loop_duty[8:1])) else $error("out2 below loop duty");
  c_bind_write: cover property (reg_wr && reg_addr == 8'h35);
  c_loop_on: cover property (loop_duty != 9'h000);
  c_fan_pulse: cover property (fan_output_1 && out1_duty_report != 8'hff);
endmodule // pfl_monitor
bind pfl_fan_loop pfl_monitor pfl_monitor_i (.core_clk(core_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .zone1_temp(zone1_temp), .zone2_temp(zone2_temp), .zone3_temp(zone3_temp),
  .zone4_temp(zone4_temp), .table1_temp(table1_temp), .table2_temp(table2_temp),
  .table3_temp(table3_temp), .table4_temp(table4_temp), .out1_duty_report(out1_duty_report),
  .out2_duty_report(out2_duty_report), .loop_duty(loop_duty), .fan_output_1(fan_output_1));
`default_nettype wire

// *** pfl_fan_model.sv ***
/*
 Fan model: counts the cycles its PWM drive is high since the last clear.
 Assumes the drive is synchronous to core_clk.
*/
`default_nettype none
module pfl_fan_model (
  input  wire logic        core_clk,
  input  wire logic        meas_clr,
  input  wire logic        drive_in,
  output var  logic [15:0] on_cycles
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge core_clk) begin
    if (meas_clr) on_cycles <= 16'h0000;
    else if (drive_in) on_cycles <= on_cycles + 16'h0001;
  end
endmodule // pfl_fan_model
`default_nettype wire

// *** pfl_fan_loop_tb.sv ***
/*
 Self-checking testbench of the fan loop setup block with two fan models.
 Assumes short filter and loop ticks and a PWM phase step of one clock.
*/
`default_nettype none
module pfl_fan_loop_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] a, rv, wd, ex;} pfl_row_t;
  logic       core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, meas_clr = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, t1, t2, t3, t4, rep1, rep2;
  logic [7:0] z1 = 8'h28, z2 = 8'h11, z3 = 8'h22, z4 = 8'h33;
  logic [8:0] low1 = 9'h000, low2 = 9'h000, loop_duty, d [4];
  logic       fan1, fan2;
  logic [15:0] on1, on2;
  logic [1:0] ex [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  int         fail_count = 0, check_count = 0, cycles = 0;
  pfl_row_t   rows [14] = '{
    '{8'h32, 8'h00, 8'hff, 8'h77}, '{8'h33, 8'h00, 8'hff, 8'hf8},
    '{8'h34, 8'h00, 8'hff, 8'hf8}, '{8'h35, 8'h30, 8'h5a, 8'h5a},
    '{8'h36, 8'h00, 8'ha5, 8'ha5}, '{8'h37, 8'h00, 8'h1e, 8'h1e},
    '{8'h38, 8'h00, 8'h2d, 8'h2d}, '{8'h39, 8'h80, 8'h7f, 8'h7f},
    '{8'h3a, 8'h80, 8'h33, 8'h33}, '{8'h3b, 8'h00, 8'hc3, 8'hc3},
    '{8'h3c, 8'h00, 8'h3c, 8'h3c}, '{8'h3d, 8'h00, 8'hff, 8'h0f},
    '{8'h3e, 8'h00, 8'hff, 8'h00}, '{8'h31, 8'h00, 8'hff, 8'h00}};
  pfl_fan_loop #(.FILT_TICK_CYC(4), .PI_TICK_CYC(8), .PWM_DIV(1)) pfl_fan_loop_i (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(rdata), .zone1_temp(z1), .zone2_temp(z2),
    .zone3_temp(z3), .zone4_temp(z4), .out1_lowres_duty(low1), .out2_lowres_duty(low2),
    .table1_temp(t1), .table2_temp(t2), .table3_temp(t3), .table4_temp(t4),
    .out1_duty_report(rep1), .out2_duty_report(rep2), .loop_duty(loop_duty),
    .fan_output_1(fan1), .fan_output_2(fan2));
  pfl_fan_model pfl_fan_model_i (.core_clk(core_clk), .meas_clr(meas_clr),
    .drive_in(fan1), .on_cycles(on1));
  pfl_fan_model pfl_fan_model_i2 (.core_clk(core_clk), .meas_clr(meas_clr),
    .drive_in(fan2), .on_cycles(on2));
  always #2.5 core_clk = ~core_clk;
  // ----------------------------------------------------------------
  // Bench tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk) #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge core_clk) #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk) #1;
    reg_addr = a;
    #1 chk("reg read", e, rdata);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Counts over exactly two PWM periods so the phase start does not matter
  task automatic meas();
    @(posedge core_clk) #1 meas_clr = 1'b1;
    @(posedge core_clk) #1 meas_clr = 1'b0;
    cyc(512);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(6);
    rst = 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].a, rows[i].rv);
      wr(rows[i].a, rows[i].wd);
      rd(rows[i].a, rows[i].ex);
    end
    foreach (rows[i]) wr(rows[i].a, rows[i].rv);
    wr(8'h33, 8'hf8);
    low1 = 9'h010;
    cyc(4);
    chk("bypass rep1", 8'h08, rep1);
    meas();
    chk("fan1 on", 16'd32, on1);
    low1 = 9'h0f0;
    wr(8'h32, 8'h01);
    cyc(400);
    chk("cut rep1", 8'h00, rep1);
    wr(8'h33, 8'he8);
    cyc(400);
    chk("pass rep1", 1'b1, rep1 >= 8'h70);
    low1 = 9'h000;
    wr(8'h33, 8'h00);
    cyc(400);
    wr(8'h32, 8'h07);
    low1 = 9'h0f0;
    cyc(40);
    chk("slow rep1", 1'b1, rep1 < 8'h40);
    wr(8'h32, 8'h01);
    cyc(40);
    chk("fast rep1", 1'b1, rep1 >= 8'h70);
    low1 = 9'h000;
    low2 = 9'h0a0;
    wr(8'h32, 8'h00);
    cyc(4);
    chk("bypass rep2", 8'h50, rep2);
    low2 = 9'h000;
    wr(8'h37, 8'h1e);
    wr(8'h36, 8'h40);
    wr(8'h35, 8'h05);
    cyc(40);
    chk("floor duty", 9'h040, loop_duty);
    chk("loop rep1", 8'h20, rep1);
    chk("loop rep2", 8'h00, rep2);
    meas();
    chk("fan1 loop", 16'd128, on1);
    chk("fan2 loop", 16'd0, on2);
    wr(8'h39, 8'h28);
    cyc(20);
    chk("off duty", 9'h000, loop_duty);
    wr(8'h39, 8'h80);
    cyc(20);
    chk("off disabled", 9'h040, loop_duty);
    wr(8'h36, 8'h00);
    wr(8'h3b, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(8'h3d, {4'h0, ex[i], 2'b00});
      cyc(20);
      d[i] = loop_duty;
    end
    chk("p exp 0", 1'b1, d[0] != 9'h000);
    chk("p exp +1", {d[0], 1'b0}, d[1]);
    chk("p exp -1", d[0], {d[2], 1'b0});
    chk("p exp -2", d[0], {d[3], 2'b00});
    wr(8'h3b, 8'h00);
    wr(8'h3c, 8'h10);
    wr(8'h3d, 8'h01);
    cyc(16);
    d[0] = loop_duty;
    cyc(40);
    chk("integral rise", 1'b1, loop_duty > d[0]);
    wr(8'h36, 8'h0f);
    wr(8'h37, 8'h2b);
    cyc(20);
    chk("hyst hold", 9'h100, loop_duty);
    wr(8'h36, 8'h00);
    cyc(20);
    chk("below band", 1'b1, loop_duty < 9'h100);
    wr(8'h35, 8'h06);
    wr(8'h3a, 8'h11);
    cyc(3);
    chk("zone2 off", 9'h000, loop_duty);
    wr(8'h35, 8'h00);
    cyc(3);
    chk("unbound duty", 9'h000, loop_duty);
    wr(8'h35, 8'hf0);
    cyc(2);
    chk("table3 zone1", 8'h28, t3);
    chk("table4 zone2", 8'h11, t4);
    rst = 1'b1;
    cyc(6);
    rst = 1'b0;
    rd(8'h35, 8'h30);
    cyc(4);
    chk("table1 reset", 8'h28, t1);
    chk("table2 reset", 8'h11, t2);
    chk("table3 reset", 8'h22, t3);
    chk("table4 reset", 8'h33, t4);
    test_done();
  end
endmodule // pfl_fan_loop_tb
`default_nettype wire
